// [cbt_pkg.sv]
/*
  Constants, encodings and state types for the bus command interpreter.
  Assumes ASCII command bytes and a 32-bit classic Wishbone register port.
*/
`default_nettype none

package cbt_pkg;
  // Characters
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_Y = 8'h59;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] CH_D0 = 8'h30;
  localparam logic [7:0] CH_D9 = 8'h39;

  // Error word bits
  localparam int ERR_W = 5;
  localparam int E_ICMD = 0;
  localparam int E_IOPT = 1;
  localparam int E_NREM = 2;
  localparam int E_TOVR = 3;
  localparam int E_NUM = 4;

  // Data condition word bits
  localparam int DATA_W = 4;
  localparam int D_FULL = 0;
  localparam int D_ZC = 1;
  localparam int D_SUP = 2;
  localparam int D_TCAL = 3;

  localparam int STORE_LOCS = 100;

  // Status query options
  localparam logic [3:0] U_ERR = 4'h1;
  localparam logic [3:0] U_DATA = 4'h2;

  // Register map (byte addresses)
  localparam logic [3:0] REG_STAT = 4'h0;
  localparam logic [3:0] REG_TERM = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam int CTRL_EN = 0;
  localparam int CTRL_CLR = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STAT_DATA_LSB = 8;

  localparam logic [3:0] OPT_BAD = 4'hF;

  // Highest legal option per command letter
  function automatic logic [3:0] opt_max(input logic [7:0] c);
    case (c)
      8'h43: opt_max = 4'h1;
      8'h46: opt_max = 4'h3;
      8'h4E: opt_max = 4'h1;
      8'h52: opt_max = 4'h7;
      8'h54: opt_max = 4'h7;
      8'h55: opt_max = 4'h2;
      8'h5A: opt_max = 4'h1;
      default: opt_max = OPT_BAD;
    endcase
  endfunction : opt_max

  typedef enum logic [3:0] {
    P_LET = 4'b0001,
    P_OPT = 4'b0010,
    P_YC1 = 4'b0100,
    P_YC2 = 4'b1000
  } cbt_pst_e;

  typedef enum logic [4:0] {
    T_IDLE = 5'b00001,
    T_WORD = 5'b00010,
    T_RDG = 5'b00100,
    T_TRM1 = 5'b01000,
    T_TRM2 = 5'b10000
  } cbt_tst_e;
endpackage : cbt_pkg

`default_nettype wire

// [cbt_cmd_mem.sv]
/*
  Command buffer memory: one write port, one read port, registered read data.
  Assumes a single clock; no reset on the storage array.
*/
`timescale 1ns/1ps
`default_nettype none

module cbt_cmd_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_adr_i,
  input wire logic [WIDTH-1:0] wr_dat_i,
  // Read port
  input wire logic [AW-1:0] rd_adr_i,
  output logic [WIDTH-1:0] rd_dat_o
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_adr_i] <= wr_dat_i;
    end
    rd_dat_o <= mem_r[rd_adr_i];
  end
endmodule : cbt_cmd_mem

`default_nettype wire

// [cbt_top.sv]
/*
  Command interpreter: parses command bytes, buffers them until execute,
  keeps error and data condition flags, and sends status words and readings
  followed by the programmed terminator.
  Assumes all inputs synchronous to clk_i and a classic Wishbone master.
*/
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module cbt_top #(
  parameter int BUF_DEPTH = 16,
  parameter int STORE_LOCS = cbt_pkg::STORE_LOCS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command bytes from the bus
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_stb_i,
  input wire logic ren_i,
  input wire logic dev_clr_i,
  input wire logic talk_i,
  output logic rx_busy_o,
  // Output bytes to the bus
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // Reading string source
  input wire logic [7:0] rdg_byte_i,
  input wire logic rdg_valid_i,
  input wire logic rdg_last_i,
  output logic rdg_ready_o,
  // Instrument events and state
  input wire logic trig_i,
  input wire logic conv_busy_i,
  input wire logic cal_oor_i,
  input wire logic cal_new_i,
  input wire logic nv_recall_err_i,
  input wire logic nv_save_i,
  input wire logic store_wr_i,
  input wire logic store_rd_req_i,
  input wire logic zc_i,
  input wire logic sup_i,
  // Executed commands
  output logic cmd_valid_o,
  output logic [7:0] cmd_letter_o,
  output logic [3:0] cmd_opt_o,
  output logic err_bit_o
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int CW = $clog2(STORE_LOCS + 1);
  localparam logic [CW-1:0] STORE_LAST = CW'(STORE_LOCS - 1);

  cbt_pkg::cbt_pst_e pst_r, pst_nxt;
  cbt_pkg::cbt_tst_e tst_r;
  logic [7:0] let_r, let_nxt;
  logic [2:0] err_cmd;
  logic [4:0] err_r, err_set, w_snap_r, dflags;
  logic bad_r, wr_en, as_let, go_x, x_run, x_disc, is_dig, is_cap;
  logic t_ld, t_en, t_two, tp_vld_r, tp_en_r, tp_two_r;
  logic [7:0] t_b0, t_b1, tp_b0_r, tp_b1_r;
  logic tm_en_r, tm_two_r;
  logic [7:0] tm_b0_r, tm_b1_r;
  logic [AW:0] wr_ptr_r, rd_ptr_r;
  logic exec_r, rd_vld_r;
  logic [11:0] mem_rd;
  logic err_req_r, data_req_r, err_start, data_start;
  logic w_sel_r;
  logic [2:0] w_idx_r;
  logic ld, w_bit, w_last;
  logic [CW-1:0] st_cnt_r;
  logic full_r, tcal_r, ctrl_en_r, bus_clr_r, clr, wb_req;

  assign clr = dev_clr_i || bus_clr_r;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Command byte decode
  always_comb begin
    pst_nxt = pst_r;
    let_nxt = let_r;
    err_cmd = '0;
    wr_en = 1'b0;
    as_let = 1'b0;
    go_x = 1'b0;
    t_ld = 1'b0;
    t_en = 1'b1;
    t_two = 1'b0;
    t_b0 = rx_byte_i;
    t_b1 = rx_byte_i;
    is_dig = rx_byte_i >= cbt_pkg::CH_D0 && rx_byte_i <= cbt_pkg::CH_D9;
    is_cap = rx_byte_i >= cbt_pkg::CH_A && rx_byte_i <= cbt_pkg::CH_Z;
    if (rx_stb_i && ctrl_en_r && !exec_r) begin
      case (pst_r)
        cbt_pkg::P_LET: as_let = 1'b1;
        cbt_pkg::P_OPT: begin
          pst_nxt = cbt_pkg::P_LET;
          if (!is_dig || rx_byte_i[3:0] > cbt_pkg::opt_max(let_r)) begin
            err_cmd[1] = 1'b1;
          end else if (wr_ptr_r[AW]) begin
            err_cmd[0] = 1'b1;
          end else begin
            wr_en = 1'b1;
          end
        end
        cbt_pkg::P_YC1: begin
          pst_nxt = cbt_pkg::P_LET;
          if (rx_byte_i == cbt_pkg::CH_X) begin
            t_ld = 1'b1;
            t_en = 1'b0;
            go_x = 1'b1;
          end else if (is_cap) begin
            err_cmd[1] = 1'b1;
          end else if (rx_byte_i == cbt_pkg::CH_CR || rx_byte_i == cbt_pkg::CH_LF) begin
            let_nxt = rx_byte_i;
            pst_nxt = cbt_pkg::P_YC2;
          end else begin
            t_ld = 1'b1;
          end
        end
        cbt_pkg::P_YC2: begin
          pst_nxt = cbt_pkg::P_LET;
          t_ld = 1'b1;
          t_b0 = let_r;
          if ((let_r == cbt_pkg::CH_CR && rx_byte_i == cbt_pkg::CH_LF) ||
              (let_r == cbt_pkg::CH_LF && rx_byte_i == cbt_pkg::CH_CR)) begin
            t_two = 1'b1;
          end else begin
            as_let = 1'b1;
          end
        end
        default: pst_nxt = cbt_pkg::P_LET;
      endcase
      if (as_let) begin
        if (rx_byte_i == cbt_pkg::CH_X) begin
          go_x = 1'b1;
        end else if (!ren_i) begin
          err_cmd[2] = 1'b1;
        end else if (rx_byte_i == cbt_pkg::CH_Y) begin
          pst_nxt = cbt_pkg::P_YC1;
        end else if (cbt_pkg::opt_max(rx_byte_i) == cbt_pkg::OPT_BAD) begin
          err_cmd[0] = 1'b1;
        end else begin
          let_nxt = rx_byte_i;
          pst_nxt = cbt_pkg::P_OPT;
        end
      end
    end
  end

  assign x_disc = go_x && bad_r;
  assign x_run = go_x && !bad_r;

  // Parser state and pending terminator
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      pst_r <= cbt_pkg::P_LET;
      let_r <= 8'h00;
      bad_r <= 1'b0;
      tp_vld_r <= 1'b0;
      tp_en_r <= 1'b0;
      tp_two_r <= 1'b0;
      tp_b0_r <= 8'h00;
      tp_b1_r <= 8'h00;
    end else begin
      pst_r <= pst_nxt;
      let_r <= let_nxt;
      if (go_x) begin
        bad_r <= 1'b0;
        tp_vld_r <= 1'b0;
      end else begin
        if (|err_cmd) begin
          bad_r <= 1'b1;
        end
        if (t_ld) begin
          tp_vld_r <= 1'b1;
          tp_en_r <= t_en;
          tp_two_r <= t_two;
          tp_b0_r <= t_b0;
          tp_b1_r <= t_b1;
        end
      end
    end
  end

  // Active terminator
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      tm_en_r <= 1'b1;
      tm_two_r <= 1'b1;
      tm_b0_r <= cbt_pkg::CH_CR;
      tm_b1_r <= cbt_pkg::CH_LF;
    end else if (x_run && t_ld) begin
      tm_en_r <= t_en;
      tm_two_r <= t_two;
      tm_b0_r <= t_b0;
      tm_b1_r <= t_b1;
    end else if (x_run && tp_vld_r) begin
      tm_en_r <= tp_en_r;
      tm_two_r <= tp_two_r;
      tm_b0_r <= tp_b0_r;
      tm_b1_r <= tp_b1_r;
    end
  end

  // Command buffer and execution
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      exec_r <= 1'b0;
      rd_vld_r <= 1'b0;
    end else begin
      rd_vld_r <= exec_r && rd_ptr_r != wr_ptr_r;
      if (x_disc) begin
        wr_ptr_r <= '0;
      end else if (x_run) begin
        exec_r <= 1'b1;
        rd_ptr_r <= '0;
      end else if (exec_r && rd_ptr_r == wr_ptr_r) begin
        exec_r <= 1'b0;
        wr_ptr_r <= '0;
      end else if (exec_r) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end else if (wr_en) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
    end
  end

  cbt_cmd_mem #(
    .WIDTH(12),
    .DEPTH(BUF_DEPTH),
    .AW(AW)
  ) u_mem (
    .clk_i(clk_i),
    .wr_en_i(wr_en),
    .wr_adr_i(wr_ptr_r[AW-1:0]),
    .wr_dat_i({let_r, rx_byte_i[3:0]}),
    .rd_adr_i(rd_ptr_r[AW-1:0]),
    .rd_dat_o(mem_rd)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_letter_o <= 8'h00;
      cmd_opt_o <= 4'h0;
    end else begin
      cmd_valid_o <= rd_vld_r;
      cmd_letter_o <= mem_rd[11:4];
      cmd_opt_o <= mem_rd[3:0];
    end
  end

  // Word requests, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      err_req_r <= 1'b0;
      data_req_r <= 1'b0;
    end else begin
      if (err_start) begin
        err_req_r <= 1'b0;
      end
      if (data_start) begin
        data_req_r <= 1'b0;
      end
      if (rd_vld_r && mem_rd[11:4] == cbt_pkg::CH_U) begin
        if (mem_rd[3:0] == cbt_pkg::U_ERR) begin
          err_req_r <= 1'b1;
        end
        if (mem_rd[3:0] == cbt_pkg::U_DATA) begin
          data_req_r <= 1'b1;
        end
      end
    end
  end

  // Error flags
  always_comb begin
    err_set = '0;
    err_set[cbt_pkg::E_ICMD] = err_cmd[0];
    err_set[cbt_pkg::E_IOPT] = err_cmd[1];
    err_set[cbt_pkg::E_NREM] = err_cmd[2];
    err_set[cbt_pkg::E_TOVR] = trig_i && conv_busy_i;
    err_set[cbt_pkg::E_NUM] = cal_oor_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_r <= '0;
      err_bit_o <= 1'b0;
    end else begin
      err_r <= (err_r & {5{!err_start}}) | err_set;
      err_bit_o <= |((err_r & {5{!err_start}}) | err_set);
    end
  end

  // Data conditions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_cnt_r <= '0;
      full_r <= 1'b0;
      tcal_r <= 1'b0;
    end else begin
      if (store_rd_req_i) begin
        st_cnt_r <= '0;
        full_r <= 1'b0;
      end else if (store_wr_i && !full_r) begin
        st_cnt_r <= st_cnt_r + 1'b1;
        full_r <= st_cnt_r == STORE_LAST;
      end
      tcal_r <= (tcal_r && !nv_save_i) || cal_new_i || nv_recall_err_i;
    end
  end

  always_comb begin
    dflags = '0;
    dflags[cbt_pkg::D_FULL] = full_r;
    dflags[cbt_pkg::D_ZC] = zc_i;
    dflags[cbt_pkg::D_SUP] = sup_i;
    dflags[cbt_pkg::D_TCAL] = tcal_r;
  end

  // Output sequencer
  assign err_start = tst_r == cbt_pkg::T_IDLE && talk_i && err_req_r;
  assign data_start = tst_r == cbt_pkg::T_IDLE && talk_i && !err_req_r && data_req_r;
  assign ld = !tx_valid_o || tx_ready_i;
  assign w_bit = w_sel_r ? w_snap_r[w_idx_r] : dflags[w_idx_r];
  assign w_last = w_idx_r == (w_sel_r ? 3'(cbt_pkg::ERR_W - 1) : 3'(cbt_pkg::DATA_W - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || clr) begin
      tst_r <= cbt_pkg::T_IDLE;
      tx_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      rdg_ready_o <= 1'b0;
      w_sel_r <= 1'b0;
      w_snap_r <= '0;
      w_idx_r <= '0;
    end else begin
      if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
      case (tst_r)
        cbt_pkg::T_IDLE: begin
          w_idx_r <= '0;
          w_sel_r <= err_req_r;
          w_snap_r <= err_r;
          if (talk_i) begin
            tst_r <= (err_req_r || data_req_r) ? cbt_pkg::T_WORD : cbt_pkg::T_RDG;
          end
        end
        cbt_pkg::T_WORD: if (ld) begin
          tx_valid_o <= 1'b1;
          tx_byte_o <= cbt_pkg::CH_D0 | {7'h00, w_bit};
          w_idx_r <= w_idx_r + 1'b1;
          if (w_last) begin
            tst_r <= tm_en_r ? cbt_pkg::T_TRM1 : cbt_pkg::T_IDLE;
          end
        end
        cbt_pkg::T_RDG: begin
          if (rdg_ready_o && rdg_valid_i) begin
            rdg_ready_o <= 1'b0;
            tx_valid_o <= 1'b1;
            tx_byte_o <= rdg_byte_i;
            if (rdg_last_i) begin
              tst_r <= tm_en_r ? cbt_pkg::T_TRM1 : cbt_pkg::T_IDLE;
            end
          end else if (!tx_valid_o) begin
            rdg_ready_o <= 1'b1;
          end
        end
        cbt_pkg::T_TRM1: if (ld) begin
          tx_valid_o <= 1'b1;
          tx_byte_o <= tm_b0_r;
          tst_r <= tm_two_r ? cbt_pkg::T_TRM2 : cbt_pkg::T_IDLE;
        end
        cbt_pkg::T_TRM2: if (ld) begin
          tx_valid_o <= 1'b1;
          tx_byte_o <= tm_b1_r;
          tst_r <= cbt_pkg::T_IDLE;
        end
        default: tst_r <= cbt_pkg::T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_busy_o <= 1'b0;
    end else begin
      rx_busy_o <= x_run || (exec_r && rd_ptr_r != wr_ptr_r);
    end
  end

  // Wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_en_r <= cbt_pkg::CTRL_EN_RST;
      bus_clr_r <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      bus_clr_r <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == cbt_pkg::REG_CTRL) begin
        ctrl_en_r <= wb_dat_i[cbt_pkg::CTRL_EN];
        bus_clr_r <= wb_dat_i[cbt_pkg::CTRL_CLR];
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          cbt_pkg::REG_STAT: wb_dat_o <= 32'(err_r) | (32'(dflags) << cbt_pkg::STAT_DATA_LSB);
          cbt_pkg::REG_TERM: wb_dat_o <= {14'h0, tm_two_r, tm_en_r, tm_b1_r, tm_b0_r};
          cbt_pkg::REG_CTRL: wb_dat_o <= {31'h0, ctrl_en_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks
  a_icmd_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    err_cmd[0] |=> err_r[cbt_pkg::E_ICMD]) else $error("illegal command not flagged");
  a_iopt_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_stb_i && ctrl_en_r && !exec_r && pst_r == cbt_pkg::P_YC1 && is_cap
     && rx_byte_i != cbt_pkg::CH_X) |=> err_r[cbt_pkg::E_IOPT])
    else $error("capital terminator not refused");
  a_nrem_flag: assert property (@(posedge clk_i) disable iff (rst_i || clr)
    (as_let && rx_byte_i != cbt_pkg::CH_X && !ren_i) |=> err_r[cbt_pkg::E_NREM] && bad_r)
    else $error("no remote not flagged");
  a_discard_str: assert property (@(posedge clk_i) disable iff (rst_i)
    x_disc |=> !cmd_valid_o [*3]) else $error("bad string executed");
  a_trig_ovr: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_i && conv_busy_i |=> err_r[cbt_pkg::E_TOVR]) else $error("overrun missed");
  a_num_err: assert property (@(posedge clk_i) disable iff (rst_i)
    cal_oor_i |=> err_r[cbt_pkg::E_NUM]) else $error("number error missed");
  a_full_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    store_rd_req_i |=> !full_r) else $error("store full not cleared");
  a_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    err_start && err_set == '0 |=> err_r == '0 && !err_bit_o)
    else $error("error word not cleared");
  a_term_reset: assert property (@(posedge clk_i)
    rst_i |=> tm_b0_r == cbt_pkg::CH_CR && tm_b1_r == cbt_pkg::CH_LF && tm_two_r && tm_en_r)
    else $error("default terminator wrong");
  a_once_data: assert property (@(posedge clk_i) disable iff (rst_i)
    data_start && !(rd_vld_r && mem_rd[11:4] == cbt_pkg::CH_U) |=> !data_req_r)
    else $error("data request not consumed");

  c_err_word: cover property (@(posedge clk_i) err_start);
  c_data_word: cover property (@(posedge clk_i) data_start);
  c_term_off: cover property (@(posedge clk_i) x_run && t_ld && !t_en);
  c_exec_cmd: cover property (@(posedge clk_i) cmd_valid_o);
endmodule : cbt_top

`default_nettype wire

// [cbt_bus_model.sv]
/*
  Far-side model: output byte sink with prompt or stalling ready, and a
  reading source that always offers the two-byte reading "42".
  Assumes the interpreter's registered handshakes on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module cbt_bus_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // Output byte sink
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // Reading source
  input wire logic rdg_ready_i,
  output logic [7:0] rdg_byte_o,
  output logic rdg_valid_o,
  output logic rdg_last_o
);
  logic [3:0] lfsr_r;
  logic idx_r;

  // Stalling sink pattern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_r <= 4'h1;
      tx_ready_o <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
      tx_ready_o <= slow_i ? (lfsr_r[0] & lfsr_r[1]) : 1'b1;
    end
  end

  // Byte advances only when taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_r <= 1'b0;
    end else if (rdg_valid_o && rdg_ready_i) begin
      idx_r <= ~idx_r;
    end
  end

  assign rdg_valid_o = ~rst_i;
  assign rdg_byte_o = idx_r ? 8'h32 : 8'h34;
  assign rdg_last_o = idx_r;
endmodule : cbt_bus_model

`default_nettype wire

// [tb.sv]
/*
  Self-checking bench for the command interpreter: Wishbone register access,
  command strings, events, talk output; executed commands compared with a queue model.
  Assumes cbt_pkg and the far-side model cbt_bus_model.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] rx_byte_i = 8'h0;
  logic rx_stb_i = 1'b0;
  logic ren_i = 1'b1;
  logic conv_busy_i = 1'b0;
  logic zc_i = 1'b0;
  logic sup_i = 1'b0;
  logic slow = 1'b0;
  logic [8:0] ev = 9'h0;
  logic rx_busy_o, tx_valid_o, tx_ready_i, rdg_valid_i, rdg_last_i, rdg_ready_o;
  logic [7:0] tx_byte_o, rdg_byte_i, cmd_letter_o;
  logic [3:0] cmd_opt_o;
  logic cmd_valid_o, err_bit_o;
  logic [31:0] q;
  int err_count = 0;
  int total_checks = 0;
  int seed = 72;
  int cyc_n = 0;
  int err = 0;
  int full = 0;
  int tcal = 0;
  logic [11:0] eq[$];
  logic [7:0] got[$];
  string ts[4] = '{"Y@X", "YAX", "Y\n\015X", "YX"};
  logic [31:0] te[4] = '{32'h00010040, 32'h00010040, 32'h00030D0A, 32'h0};
  logic [31:0] tm[4] = '{32'hFFFF00FF, 32'hFFFF00FF, 32'hFFFFFFFF, 32'h00010000};

  always #20 clk_i = ~clk_i;

  cbt_top #(.STORE_LOCS(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_byte_i(rx_byte_i),
    .rx_stb_i(rx_stb_i), .ren_i(ren_i), .dev_clr_i(ev[7]), .talk_i(ev[8]),
    .rx_busy_o(rx_busy_o), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .rdg_byte_i(rdg_byte_i), .rdg_valid_i(rdg_valid_i),
    .rdg_last_i(rdg_last_i), .rdg_ready_o(rdg_ready_o), .trig_i(ev[0]),
    .conv_busy_i(conv_busy_i), .cal_oor_i(ev[1]), .cal_new_i(ev[2]),
    .nv_recall_err_i(ev[3]), .nv_save_i(ev[4]), .store_wr_i(ev[5]),
    .store_rd_req_i(ev[6]), .zc_i(zc_i), .sup_i(sup_i), .cmd_valid_o(cmd_valid_o),
    .cmd_letter_o(cmd_letter_o), .cmd_opt_o(cmd_opt_o), .err_bit_o(err_bit_o));

  cbt_bus_model far (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .rdg_ready_i(rdg_ready_o), .rdg_byte_o(rdg_byte_i),
    .rdg_valid_o(rdg_valid_i), .rdg_last_o(rdg_last_i));

  task automatic bad(input string m, input logic [31:0] g, input logic [31:0] e);
    err_count++;
    $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
  endtask : bad

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) bad("register", g, e);
  endtask : chk_reg

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) bad("tx byte", {24'h0, g}, {24'h0, e});
  endtask : chk_byte

  task automatic chk_cmd(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) bad("command", {20'h0, g}, {20'h0, e});
  endtask : chk_cmd

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // Ack and data are taken at the rising edge that sees ack high
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) bad("no ack", 32'h0, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask : wb

  task automatic pulse(input int b);
    @(posedge clk_i);
    ev[b] <= 1'b1;
    @(posedge clk_i);
    ev[b] <= 1'b0;
  endtask : pulse

  task automatic send(input string s);
    int n;
    n = 0;
    while (rx_busy_o !== 1'b0 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    foreach (s[i]) begin
      @(posedge clk_i);
      rx_byte_i <= s[i];
      rx_stb_i <= 1'b1;
    end
    @(posedge clk_i);
    rx_stb_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    while (rx_busy_o !== 1'b0 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    repeat (4) @(posedge clk_i);
  endtask : send

  task automatic talk(input string e);
    int n;
    n = 0;
    got.delete();
    pulse(8);
    while (got.size() < e.len() && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    repeat (12) @(posedge clk_i);
    chk_reg(got.size(), e.len());
    foreach (got[i]) if (i < e.len()) chk_byte(got[i], e[i]);
  endtask : talk

  task automatic chk_stat();
    wb(cbt_pkg::REG_STAT, 1'b0, 32'h0);
    chk_reg(q, ((full | (zc_i << 1) | (sup_i << 2) | (tcal << 3)) << 8) | err);
  endtask : chk_stat

  // Monitors sample between edges
  always @(negedge clk_i) begin
    if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) got.push_back(tx_byte_o);
    if (!rst_i && cmd_valid_o === 1'b1) begin
      if (eq.size() == 0) bad("extra command", {24'h0, cmd_letter_o}, 32'h0);
      else chk_cmd({cmd_letter_o, cmd_opt_o}, eq.pop_front());
    end
  end

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad("timeout", cyc_n, 32'h0);
      print_verdict();
    end
  end

  initial begin
    int opt;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(cbt_pkg::REG_TERM, 1'b0, 32'h0);
    chk_reg(q, 32'h00030A0D);
    chk_stat();
    wb(4'hC, 1'b0, 32'h0);
    chk_reg(q, 32'h0);
    opt = $unsigned($random(seed)) % 4;
    eq.push_back({8'h46, 4'(opt)});
    send($sformatf("F%0dX", opt));
    eq.push_back({8'h46, 4'h2});
    send("F2");
    chk_reg(eq.size(), 1);
    send("X");
    chk_reg(eq.size(), 0);
    send("F1H1X");
    send("T9X");
    ren_i <= 1'b0;
    send("F1X");
    ren_i <= 1'b1;
    conv_busy_i <= 1'b1;
    pulse(0);
    conv_busy_i <= 1'b0;
    pulse(1);
    err = 31;
    chk_stat();
    chk_reg(eq.size(), 0);
    chk_byte(err_bit_o, 1'b1);
    eq.push_back({cbt_pkg::CH_U, cbt_pkg::U_ERR});
    send("U1X");
    talk("11111\015\n");
    err = 0;
    chk_stat();
    chk_byte(err_bit_o, 1'b0);
    talk("42\015\n");
    repeat (4) pulse(5);
    full = 1;
    pulse(2);
    tcal = 1;
    eq.push_back({cbt_pkg::CH_U, cbt_pkg::U_DATA});
    send("U2X");
    zc_i <= 1'b1;
    slow <= 1'b1;
    talk("1101\015\n");
    slow <= 1'b0;
    chk_stat();
    talk("42\015\n");
    pulse(6);
    full = 0;
    pulse(4);
    tcal = 0;
    chk_stat();
    sup_i <= 1'b1;
    pulse(3);
    tcal = 1;
    chk_stat();
    for (int i = 0; i < 4; i++) begin
      send(ts[i]);
      wb(cbt_pkg::REG_TERM, 1'b0, 32'h0);
      chk_reg(q & tm[i], te[i]);
      if (i == 0) talk("42@");
    end
    talk("42");
    // Bytes are ignored while the interpreter is disabled
    wb(cbt_pkg::REG_CTRL, 1'b1, 32'h0);
    wb(cbt_pkg::REG_CTRL, 1'b0, 32'h0);
    chk_reg(q, 32'h0);
    send("F1X");
    wb(cbt_pkg::REG_CTRL, 1'b1, 32'h1);
    pulse(7);
    wb(cbt_pkg::REG_TERM, 1'b0, 32'h0);
    chk_reg(q, 32'h00030A0D);
    send("Y@X");
    wb(cbt_pkg::REG_CTRL, 1'b1, 32'h3);
    wb(cbt_pkg::REG_TERM, 1'b0, 32'h0);
    chk_reg(q, 32'h00030A0D);
    print_verdict();
  end
endmodule : tb

`default_nettype wire
